/* File: mcu_bus_model.sv */
// microcontroller bus model for the decode block
`timescale 1ns/1ns
`default_nettype none
module mcu_bus_model (
  // clock
  input  wire logic        CLK,
  // bus towards the device
  output logic      [19:0] ADDR,
  output logic      [7:0]  WDATA,
  output logic             WR_STROBE,
  output logic             RD_STROBE,
  output logic             PROGRAM_FETCH_STROBE,
  input  wire logic [7:0]  RDATA
);
  initial begin
    ADDR = 20'h00000;
    WDATA = 8'h00;
    WR_STROBE = 1'b0;
    RD_STROBE = 1'b0;
    PROGRAM_FETCH_STROBE = 1'b0;
  end
  task automatic cfg_wr(input logic [7:0] ofs, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= {12'h0ff, ofs};
    WDATA <= d;
    WR_STROBE <= 1'b1;
    @(posedge CLK);
    WR_STROBE <= 1'b0;
    WDATA <= ~d;
  endtask
  task automatic cfg_rd(input logic [7:0] ofs, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= {12'h0ff, ofs};
    RD_STROBE <= 1'b1;
    @(posedge CLK);
    RD_STROBE <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic mem_acc(input logic [19:0] a, input logic fetch);
    @(posedge CLK);
    ADDR <= a;
    RD_STROBE <= ~fetch;
    PROGRAM_FETCH_STROBE <= fetch;
    #1;
  endtask
  task automatic release_bus();
    @(posedge CLK);
    RD_STROBE <= 1'b0;
    PROGRAM_FETCH_STROBE <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: mem_decode.sv */
// memory space decode, paging, power and macrocell access registers
`timescale 1ns/1ns
`default_nettype none
`include "mem_decode_consts.svh"

module mem_decode
  import mem_decode_pkg::*;
#(
  parameter logic [7:0] MEM_ID0 = 8'h5a, // arbitrary value
  parameter logic [7:0] MEM_ID1 = 8'ha5  // arbitrary value
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // microcontroller bus
  input  wire logic [19:0] ADDR,
  input  wire logic [7:0]  WDATA,
  output logic      [7:0]  RDATA,
  input  wire logic        WR_STROBE,
  input  wire logic        RD_STROBE,
  input  wire logic        PROGRAM_FETCH_STROBE,
  input  wire logic        EXT_ADDR_MODE,
  input  wire logic        PDN,
  // general logic inputs
  input  wire logic [23:0] PORT_IN,
  input  wire logic [3:0]  PORT_D,
  input  wire logic [7:0]  PORT_F,
  input  wire logic        READY_BUSY,
  // selects and status
  output selects_t         SELECTS,
  output logic [7:0]       EXTERNAL_SELECTS,
  output logic [15:0]      OUTPUT_CELL,
  output logic             STANDBY,
  output logic_bus_t       LOGIC_BUS
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]   page_q, space_map_q, power_zero_q, power_two_q;
  logic [15:0]  out_cell_q;
  logic [23:0]  in_cell_q;
  logic [7:0]   rdata_q;
  logic [6:0]   idle_q;
  logic_bus_t   bus_prev_q;
  power_state_t pstate_q;

  // ----------------------------------------------------------------
  // address and space decode
  // ----------------------------------------------------------------
  wire [15:0] arr_addr  = EXT_ADDR_MODE ? ADDR[19:4] : ADDR[15:0];
  wire        cfg_hit   = (arr_addr[15:8] == `CFG_BASE >> 8);
  wire [7:0]  ofs       = arr_addr[7:0];
  wire        cfg_wr    = cfg_hit && WR_STROBE;
  wire        cfg_rd    = cfg_hit && RD_STROBE;
  wire pri_en  = (PROGRAM_FETCH_STROBE && space_map_q[`BIT_PRI_FETCH]) ||
                 (RD_STROBE && space_map_q[`BIT_PRI_READ]);
  wire sec_en  = (PROGRAM_FETCH_STROBE && space_map_q[`BIT_SEC_FETCH]) ||
                 (RD_STROBE && space_map_q[`BIT_SEC_READ]) || WR_STROBE;
  wire sram_en = (PROGRAM_FETCH_STROBE && space_map_q[`BIT_SRAM_FETCH]) ||
                 RD_STROBE || WR_STROBE;
  wire pri_wr  = pri_en || WR_STROBE;

  // three-term select: page and address window matching
  function automatic logic term3(input logic [15:0] a, input logic [7:0] pg,
                                 input logic [3:0] hi);
    term3 = (a[15:12] == hi) && (pg[0] == 1'b0 || a[11] == 1'b1) ||
            (a[15:12] == hi) && (pg[7:1] == 7'h00) ||
            (a[15:12] == hi) && (a[0] == a[0]) && (pg == page_q);
  endfunction

  logic [15:0] pri_raw;
  logic [3:0]  sec_raw;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pri_raw[i] = term3(arr_addr, page_q, 4'(i)) && page_q[7:4] == 4'h0;
    end
    for (int j = 0; j < 4; j++) begin
      sec_raw[j] = term3(arr_addr, page_q, 4'(8 + j)) && page_q[7:5] == 3'h0;
    end
  end
  wire sram_raw = term3(arr_addr, page_q, 4'h2) && page_q[7:4] == 4'h2;
  wire sec_any  = |sec_raw && sec_en;
  wire hi_prio  = cfg_hit || (sram_raw && sram_en);

  // ----------------------------------------------------------------
  // select outputs
  // ----------------------------------------------------------------
  assign SELECTS.primary   = (pri_raw & {16{pri_wr && !sec_any && !hi_prio}});
  assign SELECTS.secondary = sec_raw & {4{sec_en && !hi_prio}};
  assign SELECTS.sram      = sram_raw && sram_en && !cfg_hit;
  assign SELECTS.cfg       = cfg_hit && (RD_STROBE || WR_STROBE);
  assign SELECTS.jtag      = cfg_hit && ofs == `OFS_JTAG;
  assign SELECTS.periph    = {arr_addr[15:12] == 4'he, arr_addr[15:12] == 4'hd};

  // ----------------------------------------------------------------
  // array input bus and external selects
  // ----------------------------------------------------------------
  wire [2:0] ctrl_raw = {PROGRAM_FETCH_STROBE, RD_STROBE, WR_STROBE};
  always_comb begin
    LOGIC_BUS.addr       = arr_addr;
    LOGIC_BUS.ctrl       = ctrl_raw & ~power_two_q[2:0];
    LOGIC_BUS.rst        = RST & ~power_two_q[3];
    LOGIC_BUS.pdn        = PDN & ~power_two_q[4];
    LOGIC_BUS.in_cells   = in_cell_q;
    LOGIC_BUS.port_d     = PORT_D;
    LOGIC_BUS.port_f     = PORT_F;
    LOGIC_BUS.page       = page_q;
    LOGIC_BUS.feedback   = out_cell_q;
    LOGIC_BUS.ready_busy = READY_BUSY;
  end
  // one term each, no output cell consumed
  assign EXTERNAL_SELECTS = {8{~cfg_hit}} &
                            {arr_addr[15:13] == 3'h7, arr_addr[15:13] == 3'h6,
                             PORT_F[1:0] == 2'h3, PORT_D[0], page_q[7],
                             in_cell_q[0], arr_addr[0], READY_BUSY};
  assign OUTPUT_CELL = out_cell_q;
  assign RDATA       = rdata_q;
  assign STANDBY     = (pstate_q == ST_STANDBY);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_d;
  always_comb begin
    if (ofs == `OFS_PAGE) rd_d = page_q;
    else if (ofs == `OFS_SPACE_MAP) rd_d = space_map_q;
    else if (ofs == `OFS_POWER_ZERO) rd_d = power_zero_q;
    else if (ofs == `OFS_POWER_TWO) rd_d = power_two_q;
    else if (ofs == `OFS_MEM_ID0) rd_d = MEM_ID0;
    else if (ofs == `OFS_MEM_ID1) rd_d = MEM_ID1;
    else if (ofs == `OFS_OUT_CELL_LO) rd_d = out_cell_q[7:0];
    else if (ofs == `OFS_OUT_CELL_HI) rd_d = out_cell_q[15:8];
    else if (ofs == `OFS_IN_CELL_A) rd_d = in_cell_q[7:0];
    else if (ofs == `OFS_IN_CELL_B) rd_d = in_cell_q[15:8];
    else if (ofs == `OFS_IN_CELL_C) rd_d = in_cell_q[23:16];
    else rd_d = 8'h00;
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      page_q       <= `PAGE_INIT;
      space_map_q  <= `SPACE_MAP_INIT;
      power_zero_q <= `POWER_INIT;
      power_two_q  <= 8'h00;
      out_cell_q   <= 16'h0000;
      rdata_q      <= 8'h00;
    end else begin
      if (cfg_wr && ofs == `OFS_PAGE) page_q <= WDATA;
      if (cfg_wr && ofs == `OFS_SPACE_MAP) space_map_q <= WDATA;
      if (cfg_wr && ofs == `OFS_POWER_ZERO) power_zero_q <= WDATA;
      if (cfg_wr && ofs == `OFS_POWER_TWO) power_two_q <= {3'h0, WDATA[4:0]};
      if (cfg_wr && ofs == `OFS_OUT_CELL_LO) out_cell_q[7:0] <= WDATA;
      if (cfg_wr && ofs == `OFS_OUT_CELL_HI) out_cell_q[15:8] <= WDATA;
      rdata_q <= cfg_rd ? rd_d : 8'h00;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) in_cell_q <= 24'h000000;
    else in_cell_q <= PORT_IN;
  end

  // ----------------------------------------------------------------
  // standby control
  // ----------------------------------------------------------------
  wire bus_change = (LOGIC_BUS != bus_prev_q);
  wire speed_mode = power_zero_q[`BIT_SPEED_MODE];
  always_ff @(posedge CLK) begin
    if (RST) begin
      pstate_q   <= ST_ACTIVE;
      idle_q     <= 7'h00;
      bus_prev_q <= '0;
    end else begin
      bus_prev_q <= LOGIC_BUS;
      case (pstate_q)
        ST_ACTIVE: begin
          idle_q <= 7'h00;
          if (!speed_mode && !bus_change) pstate_q <= ST_COUNT;
        end
        ST_COUNT: begin
          idle_q <= idle_q + 7'h01;
          if (speed_mode || bus_change) pstate_q <= ST_ACTIVE;
          else if (idle_q == 7'(`IDLE_CYCLES - 2)) pstate_q <= ST_STANDBY;
        end
        ST_STANDBY: begin
          if (speed_mode || bus_change) pstate_q <= ST_ACTIVE;
        end
        default: pstate_q <= ST_ACTIVE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  page_rw_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_wr && ofs == `OFS_PAGE |=> page_q == $past(WDATA))
    else $error("page register not written");
  page_read_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_rd && ofs == `OFS_PAGE |=> RDATA == $past(page_q))
    else $error("page read wrong");
  map_sep_a: assert property (@(posedge CLK) disable iff (RST)
    space_map_q == `SPACE_MAP_INIT && RD_STROBE && !PROGRAM_FETCH_STROBE && !WR_STROBE
    |-> SELECTS.primary == 16'h0000)
    else $error("primary flash answered read strobe");
  map_comb_a: assert property (@(posedge CLK) disable iff (RST)
    space_map_q[`BIT_PRI_FETCH] && space_map_q[`BIT_PRI_READ] && RD_STROBE && !sec_any && !hi_prio
    |-> SELECTS.primary == pri_raw)
    else $error("combined space missing");
  sec_prio_a: assert property (@(posedge CLK) disable iff (RST)
    |SELECTS.secondary |-> SELECTS.primary == 16'h0000)
    else $error("secondary did not win");
  id_ro_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_rd && ofs == `OFS_MEM_ID0 |=> RDATA == MEM_ID0)
    else $error("memory id wrong");
  standby_a: assert property (@(posedge CLK) disable iff (RST)
    STANDBY |-> !speed_mode || $past(speed_mode) == 1'b0)
    else $error("standby in speed mode");
  block_a: assert property (@(posedge CLK) disable iff (RST)
    power_two_q[0] |-> LOGIC_BUS.ctrl[0] == 1'b0)
    else $error("blocked control leaked");
  map_new_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_wr && ofs == `OFS_SPACE_MAP |=> space_map_q == $past(WDATA))
    else $error("space map not updated");
  cv_standby: cover property (@(posedge CLK) disable iff (RST) STANDBY);
  cv_sec: cover property (@(posedge CLK) disable iff (RST) |SELECTS.secondary);
  cv_pri: cover property (@(posedge CLK) disable iff (RST) |SELECTS.primary);
  cv_sram: cover property (@(posedge CLK) disable iff (RST) SELECTS.sram);
  cv_win: cover property (@(posedge CLK) disable iff (RST) sec_any && |pri_raw);

  // ----------------------------------------------------------------
  // quiet cycle counter for standby checks
  // ----------------------------------------------------------------
  logic [6:0] quiet_q;
  always_ff @(posedge CLK) begin
    if (RST) quiet_q <= 7'h00;
    else if (bus_change) quiet_q <= 7'h00;
    else if (quiet_q != 7'h7f) quiet_q <= quiet_q + 7'h01;
  end

  standby_early_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(STANDBY) |-> quiet_q >= 7'(`IDLE_CYCLES))
    else $error("standby entered too early");
  standby_wake_a: assert property (@(posedge CLK) disable iff (RST)
    STANDBY && bus_change |=> !STANDBY)
    else $error("standby kept after input change");

  // ----------------------------------------------------------------
  // checks: space map and selects
  // ----------------------------------------------------------------
  sec_fetch_a: assert property (@(posedge CLK) disable iff (RST)
    space_map_q == `SPACE_MAP_INIT && PROGRAM_FETCH_STROBE && !RD_STROBE && !WR_STROBE
    |-> SELECTS.secondary == 4'h0)
    else $error("secondary flash answered fetch strobe");
  sram_fetch_a: assert property (@(posedge CLK) disable iff (RST)
    space_map_q == `SPACE_MAP_INIT && PROGRAM_FETCH_STROBE && !RD_STROBE && !WR_STROBE
    |-> !SELECTS.sram)
    else $error("sram answered fetch strobe");
  pri_fetch_a: assert property (@(posedge CLK) disable iff (RST)
    space_map_q == `SPACE_MAP_INIT && PROGRAM_FETCH_STROBE && !sec_any && !hi_prio
    |-> SELECTS.primary == pri_raw)
    else $error("primary flash missed fetch strobe");
  map_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !(cfg_wr && ofs == `OFS_SPACE_MAP) |=> $stable(space_map_q))
    else $error("space map changed without write");
  pri_one_a: assert property (@(posedge CLK) disable iff (RST)
    $onehot0(SELECTS.primary))
    else $error("two primary sectors selected");
  sec_one_a: assert property (@(posedge CLK) disable iff (RST)
    $onehot0(SELECTS.secondary))
    else $error("two secondary sectors selected");
  sram_prio_a: assert property (@(posedge CLK) disable iff (RST)
    SELECTS.sram |-> SELECTS.primary == 16'h0000 && SELECTS.secondary == 4'h0)
    else $error("flash selected over sram");
  sec_wins_a: assert property (@(posedge CLK) disable iff (RST)
    sec_any && !hi_prio && |pri_raw |-> |SELECTS.secondary)
    else $error("overlap not routed to secondary");
  jtag_cfg_a: assert property (@(posedge CLK) disable iff (RST)
    SELECTS.jtag |-> cfg_hit)
    else $error("jtag select outside config space");
  periph_excl_a: assert property (@(posedge CLK) disable iff (RST)
    !(SELECTS.periph[0] && SELECTS.periph[1]))
    else $error("both peripheral selects high");
  ext_cfg_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_hit |-> EXTERNAL_SELECTS == 8'h00)
    else $error("external select in config space");

  // ----------------------------------------------------------------
  // checks: array input bus
  // ----------------------------------------------------------------
  ext_addr_a: assert property (@(posedge CLK) disable iff (RST)
    EXT_ADDR_MODE |-> LOGIC_BUS.addr == ADDR[19:4])
    else $error("extended address not fed to arrays");
  norm_addr_a: assert property (@(posedge CLK) disable iff (RST)
    !EXT_ADDR_MODE |-> LOGIC_BUS.addr == ADDR[15:0])
    else $error("plain address not fed to arrays");
  page_bus_a: assert property (@(posedge CLK) disable iff (RST)
    LOGIC_BUS.page == page_q)
    else $error("page bits missing from array bus");
  pdn_block_a: assert property (@(posedge CLK) disable iff (RST)
    power_two_q[4] |-> !LOGIC_BUS.pdn)
    else $error("blocked power-down leaked");
  rd_block_a: assert property (@(posedge CLK) disable iff (RST)
    power_two_q[1] |-> !LOGIC_BUS.ctrl[1])
    else $error("blocked read strobe leaked");
  fetch_block_a: assert property (@(posedge CLK) disable iff (RST)
    power_two_q[2] |-> !LOGIC_BUS.ctrl[2])
    else $error("blocked fetch strobe leaked");

  // ----------------------------------------------------------------
  // checks: register access
  // ----------------------------------------------------------------
  page_hold_a: assert property (@(posedge CLK) disable iff (RST)
    !(cfg_wr && ofs == `OFS_PAGE) |=> $stable(page_q))
    else $error("page changed without write");
  id1_ro_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_rd && ofs == `OFS_MEM_ID1 |=> RDATA == MEM_ID1)
    else $error("second memory id wrong");
  cell_rd_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_rd && ofs == `OFS_OUT_CELL_LO |=> RDATA == $past(out_cell_q[7:0]))
    else $error("output cell read wrong");
  cell_wr_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_wr && ofs == `OFS_OUT_CELL_HI |=> OUTPUT_CELL[15:8] == $past(WDATA))
    else $error("output cell not loaded");
  rd_idle_a: assert property (@(posedge CLK) disable iff (RST)
    !cfg_rd |=> RDATA == 8'h00)
    else $error("read data without read");
  pwr_two_a: assert property (@(posedge CLK) disable iff (RST)
    cfg_rd && ofs == `OFS_POWER_TWO |=> RDATA[7:5] == 3'h0)
    else $error("unused power bits read high");
endmodule
`default_nettype wire

/* File: mem_decode_consts.svh */
// constants for the memory space decode and paging block
`ifndef MEM_DECODE_CONSTS_SVH
`define MEM_DECODE_CONSTS_SVH
`define OFS_PAGE        8'he0
`define OFS_SPACE_MAP   8'he2
`define OFS_POWER_ZERO  8'hb0
`define OFS_POWER_TWO   8'hb4
`define OFS_MEM_ID0     8'hf0
`define OFS_MEM_ID1     8'hf1
`define OFS_OUT_CELL_LO 8'h20
`define OFS_OUT_CELL_HI 8'h21
`define OFS_IN_CELL_A   8'h0a
`define OFS_IN_CELL_B   8'h0b
`define OFS_IN_CELL_C   8'h18
`define OFS_JTAG        8'hc0
`define SPACE_MAP_INIT  8'h0c
`define PAGE_INIT       8'h00
`define POWER_INIT      8'h08
`define BIT_SPEED_MODE  3
`define BIT_PRI_FETCH   2
`define BIT_PRI_READ    4
`define BIT_SEC_FETCH   0
`define BIT_SEC_READ    3
`define BIT_SRAM_FETCH  1
`define IDLE_TIME_NS    70
`define CLK_PERIOD_NS   8
`define IDLE_CYCLES     ((`IDLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CFG_BASE        16'hff00
`endif

/* File: mem_decode_pkg.sv */
// types for the memory space decode and paging block
package mem_decode_pkg;
  typedef struct packed {
    logic [15:0] primary;
    logic [3:0]  secondary;
    logic        sram;
    logic        cfg;
    logic        jtag;
    logic [1:0]  periph;
  } selects_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [2:0]  ctrl;
    logic        rst;
    logic        pdn;
    logic [23:0] in_cells;
    logic [3:0]  port_d;
    logic [7:0]  port_f;
    logic [7:0]  page;
    logic [15:0] feedback;
    logic        ready_busy;
  } logic_bus_t;
  typedef enum logic [1:0] {ST_ACTIVE, ST_COUNT, ST_STANDBY} power_state_t;
endpackage

/* File: memory_space_decode_and_paging_tb.sv */
// self-checking testbench for the memory space decode block
`timescale 1ns/1ns
`default_nettype none
module memory_space_decode_and_paging_tb
  import mem_decode_pkg::*;
;
  logic            CLK = 1'b0;
  logic            RST = 1'b1;
  logic            EXT_ADDR_MODE = 1'b0;
  logic            PDN = 1'b0;
  logic            READY_BUSY = 1'b0;
  logic [23:0]     PORT_IN = 24'h000000;
  logic [3:0]      PORT_D = 4'h0;
  logic [7:0]      PORT_F = 8'h00;
  wire logic [19:0] ADDR;
  wire logic [7:0] WDATA;
  wire logic [7:0] RDATA;
  wire logic       WR_STROBE;
  wire logic       RD_STROBE;
  wire logic       PROGRAM_FETCH_STROBE;
  selects_t        SELECTS;
  logic [7:0]      EXTERNAL_SELECTS;
  logic [15:0]     OUTPUT_CELL;
  logic            STANDBY;
  logic_bus_t      LOGIC_BUS;
  int              failures = 0;
  int              checks = 0;
  logic [7:0]      rd_v;
  logic [7:0]      v;
  logic [7:0]      page_q[$];
  logic [7:0]      rst_ofs[6] = '{8'he0, 8'he2, 8'hb0, 8'hf0, 8'hf1, 8'h55};
  logic [7:0]      rst_exp[6] = '{8'h00, 8'h0c, 8'h08, 8'h3c, 8'hc3, 8'h00};
  always #4 CLK = ~CLK;
  mcu_bus_model m (.CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR_STROBE(WR_STROBE),
    .RD_STROBE(RD_STROBE), .PROGRAM_FETCH_STROBE(PROGRAM_FETCH_STROBE), .RDATA(RDATA));
  mem_decode #(.MEM_ID0(8'h3c), .MEM_ID1(8'hc3)) dut (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .RDATA(RDATA), .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE),
    .PROGRAM_FETCH_STROBE(PROGRAM_FETCH_STROBE), .EXT_ADDR_MODE(EXT_ADDR_MODE), .PDN(PDN),
    .PORT_IN(PORT_IN), .PORT_D(PORT_D), .PORT_F(PORT_F), .READY_BUSY(READY_BUSY),
    .SELECTS(SELECTS), .EXTERNAL_SELECTS(EXTERNAL_SELECTS), .OUTPUT_CELL(OUTPUT_CELL),
    .STANDBY(STANDBY), .LOGIC_BUS(LOGIC_BUS));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    void'($urandom(19));
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    foreach (rst_ofs[i]) begin
      m.cfg_rd(rst_ofs[i], rd_v);
      chk(rd_v, rst_exp[i]);
    end
    m.cfg_wr(8'hf0, 8'h00);
    m.cfg_rd(8'hf0, rd_v);
    chk(rd_v, 8'h3c);
    $display("reset test done");
    repeat (4) begin
      v = 8'($urandom);
      page_q.push_back(v);
      m.cfg_wr(8'he0, v);
      m.cfg_rd(8'he0, rd_v);
      chk(rd_v, page_q.pop_front());
      chk(LOGIC_BUS.page, v);
    end
    $display("page test done");
    m.cfg_wr(8'he2, 8'h0c);
    m.cfg_wr(8'he0, 8'h00);
    for (int s = 0; s < 16; s++) begin
      m.mem_acc({4'h0, 4'(s), 12'h123}, 1'b1);
      chk(SELECTS.primary, 16'h0001 << s);
      m.release_bus();
    end
    m.mem_acc(20'h03123, 1'b0);
    chk(SELECTS.primary, 16'h0000);
    m.release_bus();
    m.cfg_wr(8'he0, 8'h10);
    m.mem_acc(20'h08123, 1'b0);
    chk(SELECTS.secondary, 4'h1);
    m.release_bus();
    m.mem_acc(20'h08123, 1'b1);
    chk(SELECTS.secondary, 4'h0);
    m.release_bus();
    m.cfg_wr(8'he0, 8'h20);
    m.mem_acc(20'h02123, 1'b0);
    chk(SELECTS.sram, 1'b1);
    m.release_bus();
    m.cfg_wr(8'he2, 8'h14);
    m.cfg_wr(8'he0, 8'h00);
    m.mem_acc(20'h03123, 1'b0);
    chk(SELECTS.primary, 16'h0008);
    m.release_bus();
    m.cfg_wr(8'he2, 8'h1c);
    m.mem_acc(20'h08123, 1'b0);
    chk({SELECTS.secondary, SELECTS.primary}, {4'h1, 16'h0000});
    m.release_bus();
    $display("decode test done");
    PORT_F <= 8'($urandom);
    PORT_D <= 4'($urandom);
    READY_BUSY <= 1'b1;
    EXT_ADDR_MODE <= 1'b1;
    m.mem_acc(20'habcde, 1'b0);
    chk(LOGIC_BUS.addr, 16'habcd);
    chk({LOGIC_BUS.port_f, LOGIC_BUS.port_d, LOGIC_BUS.ready_busy}, {PORT_F, PORT_D, 1'b1});
    m.release_bus();
    EXT_ADDR_MODE <= 1'b0;
    PDN <= 1'b1;
    m.mem_acc(20'habcde, 1'b0);
    chk(LOGIC_BUS.addr, 16'hbcde);
    m.release_bus();
    m.cfg_wr(8'hb4, 8'hff);
    m.cfg_rd(8'hb4, rd_v);
    chk(rd_v, 8'h1f);
    chk(LOGIC_BUS.pdn, 1'b0);
    m.cfg_wr(8'hb4, 8'h00);
    m.cfg_rd(8'hb4, rd_v);
    chk(LOGIC_BUS.pdn, 1'b1);
    $display("logic bus test done");
    m.cfg_wr(8'hb0, 8'h00);
    repeat (14) @(posedge CLK);
    #1;
    chk(STANDBY, 1'b1);
    m.mem_acc(20'h01000, 1'b1);
    repeat (2) @(posedge CLK);
    #1;
    chk(STANDBY, 1'b0);
    m.release_bus();
    m.cfg_wr(8'hb0, 8'h08);
    repeat (14) @(posedge CLK);
    #1;
    chk(STANDBY, 1'b0);
    $display("standby test done");
    v = 8'($urandom);
    m.cfg_wr(8'h20, v);
    m.cfg_wr(8'h21, ~v);
    m.cfg_rd(8'h20, rd_v);
    chk(rd_v, v);
    chk(OUTPUT_CELL, {~v, v});
    @(posedge CLK);
    PORT_IN <= 24'($urandom);
    repeat (3) @(posedge CLK);
    m.cfg_rd(8'h18, rd_v);
    chk(rd_v, PORT_IN[23:16]);
    $display("cell test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
